// *** pmoc_control.sv ***
// On/off, margin and write-lock command logic of a PMBus point-of-load regulator.
// Assumes a front end on clk that hands over one decoded command per valid cycle.
//
// What this block does
// R1: Operating bit 7 enables output when set, disables when cleared, per configuration.
// R2: Operating bit 6 zero turns off at once; one uses off delay and fall.
// R3: Margin bits 5:4 pick nominal, low or high setpoint; 11b unsupported.
// R4: Bits 3:2 at 01b ignore margin faults, at 10b apply fault responses.
// R5: Power-up policy 0 starts regardless of pin; 1 needs pin and command as bits 2 and 3 select.
// R6: Configuration bit 3 decides whether the operating on bit is obeyed.
// R7: Configuration bit 2 set requires the enable pin before starting, when power-up policy bit 4 is 1.
// R8: Enable pin polarity bit: 0 active low, 1 active high.
// R9: Pin-caused turn-off: bit 0 clear uses delay and fall, set is immediate.
// R10: Clear-faults command clears all status bits and releases the alert output.
// R11: Lock 000b allows all writes; 100b only the write-lock command.
// R12: Lock 010b adds operating command; 001b adds configuration and nominal voltage.
// R13: A locked-out write changes no stored value and no regulator state.
// R14: Sequenced shutdown waits off delay in milliseconds, then ramps for fall time.
`timescale 1ns/1ps
`default_nettype none

module pmoc_control #(
    parameter int MS_CYCLES = pmoc_pkg::PMOC_MS_CYCLES
) (
    input wire logic clk,
    input wire logic srst,
    input wire pmoc_pkg::pmoc_cmd_t cmd,
    input wire logic enable_pin,
    input wire logic [pmoc_pkg::PMOC_MS_WIDTH-1:0] off_delay_ms,
    input wire logic [pmoc_pkg::PMOC_MS_WIDTH-1:0] fall_time_ms,
    output logic [7:0] rd_data,
    output logic rd_valid,
    output logic write_refused,
    output logic nominal_write_ok,
    output logic [7:0] nominal_write_data,
    output logic clear_status,
    output logic alert_release,
    output logic output_enable,
    output logic ramp_down,
    output logic [1:0] setpoint_select,
    output logic margin_faults_ignored,
    output logic margin_faults_respond
);
    import pmoc_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // Helpers.

    // Decides whether a write or send to a code passes the lock level.
    function automatic logic lock_allows(input logic [2:0] level, input logic [7:0] code);
        logic ok;
        ok = 1'b0;
        case (level)
            PMOC_LOCK_NONE: ok = 1'b1; // R11
            PMOC_LOCK_ALL: ok = (code == PMOC_CODE_WRITE_LOCK); // R11
            PMOC_LOCK_OPERATING: ok = (code == PMOC_CODE_WRITE_LOCK) ||
                (code == PMOC_CODE_OPERATING); // R12
            PMOC_LOCK_CONFIG: ok = (code == PMOC_CODE_WRITE_LOCK) ||
                (code == PMOC_CODE_OPERATING) || (code == PMOC_CODE_SWITCH_CFG) ||
                (code == PMOC_CODE_NOMINAL_VOUT); // R12
            default: ok = (code == PMOC_CODE_WRITE_LOCK);
        endcase
        return ok;
    endfunction : lock_allows

    ////////////////////////////////////////////////////////////////////////////
    // State.

    logic [7:0] operating_state_control;
    logic [7:0] output_switch_config;
    logic [7:0] write_lock_control;
    logic [7:0] next_operating_state_control;
    logic [7:0] next_output_switch_config;
    logic [7:0] next_write_lock_control;
    logic pin_meta;
    logic pin_sync;
    pmoc_state_t state;
    pmoc_state_t next_state;
    logic [31:0] tick;
    logic [31:0] next_tick;
    logic [PMOC_MS_WIDTH-1:0] ms_left;
    logic [PMOC_MS_WIDTH-1:0] next_ms_left;
    logic [7:0] next_rd_data;
    logic next_rd_valid;
    logic next_write_refused;
    logic next_nominal_write_ok;
    logic [7:0] next_nominal_write_data;
    logic next_clear_status;
    logic pin_active;
    logic pin_ok;
    logic cmd_ok;
    logic request_on;
    logic cmd_off;
    logic immediate_off;
    logic write_ok;
    logic supported;
    logic [7:0] masked;

    ////////////////////////////////////////////////////////////////////////////
    // Enable pin synchroniser and the on request.

    always_ff @(posedge clk) begin
        if (srst) begin
            pin_meta <= 1'b0;
            pin_sync <= 1'b0;
        end else begin
            pin_meta <= enable_pin;
            pin_sync <= pin_meta;
        end
    end

    // Combines the pin and the on bit as the configuration asks.
    always_comb begin
        pin_active = output_switch_config[PMOC_CFG_ENABLE_PIN_POLARITY] ?
            pin_sync : ~pin_sync; // R8
        pin_ok = ~output_switch_config[PMOC_CFG_PIN_USE] | pin_active; // R7
        cmd_ok = ~output_switch_config[PMOC_CFG_CMD_USE] |
            operating_state_control[PMOC_OP_ON_BIT]; // R1 R6
        request_on = output_switch_config[PMOC_CFG_POWER_UP_POLICY] ?
            (pin_ok & cmd_ok) : cmd_ok; // R5
        cmd_off = ~cmd_ok;
        immediate_off = cmd_off ? ~operating_state_control[PMOC_OP_SEQ_OFF_BIT] // R2
            : output_switch_config[PMOC_CFG_PIN_OFF_MODE]; // R9
    end

    ////////////////////////////////////////////////////////////////////////////
    // Command decode and register updates.

    always_comb begin
        next_operating_state_control = operating_state_control;
        next_output_switch_config = output_switch_config;
        next_write_lock_control = write_lock_control;
        next_rd_data = rd_data;
        next_rd_valid = 1'b0;
        next_write_refused = 1'b0;
        next_nominal_write_ok = 1'b0;
        next_nominal_write_data = nominal_write_data;
        next_clear_status = 1'b0;
        write_ok = lock_allows(write_lock_control[PMOC_LOCK_HI:PMOC_LOCK_LO], cmd.code);
        supported = 1'b1;
        masked = 8'h00;
        if (cmd.valid && !cmd.write) begin
            next_rd_valid = 1'b1;
            case (cmd.code)
                PMOC_CODE_OPERATING: next_rd_data = operating_state_control;
                PMOC_CODE_SWITCH_CFG: next_rd_data = output_switch_config;
                PMOC_CODE_WRITE_LOCK: next_rd_data = write_lock_control;
                default: next_rd_data = 8'h00;
            endcase
        end else if (cmd.valid && cmd.write) begin
            if (!write_ok) begin
                next_write_refused = 1'b1; // R13
            end else begin
                case (cmd.code)
                    PMOC_CODE_OPERATING: begin
                        masked = cmd.data & PMOC_OPERATING_MASK;
                        supported = (masked[PMOC_OP_MARGIN_HI:PMOC_OP_MARGIN_LO] != 2'h3) &&
                            ((masked[PMOC_OP_MFLT_HI:PMOC_OP_MFLT_LO] == PMOC_MFLT_IGNORE) ||
                            (masked[PMOC_OP_MFLT_HI:PMOC_OP_MFLT_LO] == PMOC_MFLT_RESPOND));
                        if (supported) begin
                            next_operating_state_control = masked; // R3 R4
                        end else begin
                            next_write_refused = 1'b1;
                        end
                    end
                    PMOC_CODE_SWITCH_CFG: begin
                        next_output_switch_config = cmd.data & PMOC_SWITCH_CFG_MASK;
                    end
                    PMOC_CODE_WRITE_LOCK: begin
                        masked = cmd.data & PMOC_WRITE_LOCK_MASK;
                        next_write_lock_control = masked; // R11
                    end
                    PMOC_CODE_CLEAR_FAULTS: next_clear_status = 1'b1; // R10
                    PMOC_CODE_NOMINAL_VOUT: begin
                        next_nominal_write_ok = 1'b1; // R12
                        next_nominal_write_data = cmd.data;
                    end
                    default: next_write_refused = 1'b0;
                endcase
            end
        end
    end

    // Registers the command state.
    always_ff @(posedge clk) begin
        if (srst) begin
            operating_state_control <= PMOC_OPERATING_RESET;
            output_switch_config <= PMOC_SWITCH_CFG_RESET;
            write_lock_control <= PMOC_WRITE_LOCK_RESET;
            rd_data <= 8'h00;
            rd_valid <= 1'b0;
            write_refused <= 1'b0;
            nominal_write_ok <= 1'b0;
            nominal_write_data <= 8'h00;
            clear_status <= 1'b0;
            alert_release <= 1'b0;
            setpoint_select <= PMOC_MARGIN_NOMINAL;
            margin_faults_ignored <= 1'b0;
            margin_faults_respond <= 1'b1;
        end else begin
            operating_state_control <= next_operating_state_control;
            output_switch_config <= next_output_switch_config;
            write_lock_control <= next_write_lock_control;
            rd_data <= next_rd_data;
            rd_valid <= next_rd_valid;
            write_refused <= next_write_refused;
            nominal_write_ok <= next_nominal_write_ok;
            nominal_write_data <= next_nominal_write_data;
            clear_status <= next_clear_status; // R10
            alert_release <= next_clear_status; // R10
            setpoint_select <= next_operating_state_control[PMOC_OP_MARGIN_HI:PMOC_OP_MARGIN_LO]; // R3
            margin_faults_ignored <= (next_operating_state_control[PMOC_OP_MFLT_HI:PMOC_OP_MFLT_LO]
                == PMOC_MFLT_IGNORE); // R4
            margin_faults_respond <= (next_operating_state_control[PMOC_OP_MFLT_HI:PMOC_OP_MFLT_LO]
                == PMOC_MFLT_RESPOND); // R4
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Output on/off sequencer.

    always_comb begin
        next_state = state;
        next_tick = tick;
        next_ms_left = ms_left;
        case (state)
            PMOC_OFF: begin
                if (request_on) begin
                    next_state = PMOC_ON; // R1
                end
            end
            PMOC_ON: begin
                next_tick = 32'h0;
                if (!request_on) begin
                    if (immediate_off) begin
                        next_state = PMOC_OFF; // R2 R9
                    end else if (off_delay_ms != '0) begin
                        next_state = PMOC_OFF_DELAY; // R14
                        next_ms_left = off_delay_ms;
                    end else if (fall_time_ms != '0) begin
                        next_state = PMOC_FALL; // R14
                        next_ms_left = fall_time_ms;
                    end else begin
                        next_state = PMOC_OFF;
                    end
                end
            end
            PMOC_OFF_DELAY, PMOC_FALL: begin
                next_tick = tick + 32'h1;
                if (tick == 32'(MS_CYCLES - 1)) begin
                    next_tick = 32'h0;
                    next_ms_left = ms_left - 1'b1;
                    if (ms_left == 7'h1) begin
                        if (state == PMOC_OFF_DELAY && fall_time_ms != '0) begin
                            next_state = PMOC_FALL; // R14
                            next_ms_left = fall_time_ms;
                        end else begin
                            next_state = PMOC_OFF;
                        end
                    end
                end
            end
            default: next_state = PMOC_OFF;
        endcase
    end

    // Registers the sequencer and drives the stage controls.
    always_ff @(posedge clk) begin
        if (srst) begin
            state <= PMOC_OFF;
            tick <= 32'h0;
            ms_left <= '0;
            output_enable <= 1'b0;
            ramp_down <= 1'b0;
        end else begin
            state <= next_state;
            tick <= next_tick;
            ms_left <= next_ms_left;
            output_enable <= (next_state != PMOC_OFF); // R1
            ramp_down <= (next_state == PMOC_FALL); // R14
        end
    end

endmodule : pmoc_control

`default_nettype wire

// *** pmoc_control_assertions.sv ***
// Checker for the on/off and write-lock command block.
// Assumes it is bound to pmoc_control and sees only its ports.
`timescale 1ns/1ps
`default_nettype none

module pmoc_control_assertions
    import pmoc_pkg::*;
#(
    parameter int MS_CYCLES = 4
) (
    input wire logic clk,
    input wire logic srst,
    input wire pmoc_pkg::pmoc_cmd_t cmd,
    input wire logic enable_pin,
    input wire logic [6:0] off_delay_ms,
    input wire logic [6:0] fall_time_ms,
    input wire logic [7:0] rd_data,
    input wire logic rd_valid,
    input wire logic write_refused,
    input wire logic nominal_write_ok,
    input wire logic [7:0] nominal_write_data,
    input wire logic clear_status,
    input wire logic alert_release,
    input wire logic output_enable,
    input wire logic ramp_down,
    input wire logic [1:0] setpoint_select,
    input wire logic margin_faults_ignored,
    input wire logic margin_faults_respond
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);
    logic [2:0] lock_level;
    logic [2:0] next_lock_level;
    logic wr;

    ////////////////////////////////////////////////////////////////////////////////
    // Shadow of the lock level; writes to the lock itself are never blocked.
    assign wr = cmd.valid && cmd.write;
    always_comb begin
        next_lock_level = lock_level;
        if (wr && cmd.code == PMOC_CODE_WRITE_LOCK) begin
            next_lock_level = cmd.data[PMOC_LOCK_HI:PMOC_LOCK_LO];
        end
    end
    always_ff @(posedge clk) begin
        lock_level <= srst ? 3'h0 : next_lock_level;
    end

    ////////////////////////////////////////////////////////////////////////////////
    a_read_answer: assert property (cmd.valid && !cmd.write |=> rd_valid)
        else $error("read not answered");
    a_read_cause: assert property (rd_valid |-> $past(cmd.valid && !cmd.write))
        else $error("read pulse without read");
    a_cfg_locked: assert property (
        wr && cmd.code == PMOC_CODE_SWITCH_CFG && !(lock_level inside {3'h0, 3'h1})
        |=> write_refused) else $error("locked config write not refused");
    a_nominal_pass: assert property (
        wr && cmd.code == PMOC_CODE_NOMINAL_VOUT && lock_level inside {3'h0, 3'h1}
        |=> nominal_write_ok && nominal_write_data == $past(cmd.data))
        else $error("nominal write not forwarded");
    a_clear_pulse: assert property (
        wr && cmd.code == PMOC_CODE_CLEAR_FAULTS && lock_level == 3'h0
        |=> clear_status && alert_release) else $error("clear not pulsed");
    a_clear_pair: assert property (clear_status |-> alert_release)
        else $error("alert release missing");
    a_refused_steady: assert property (write_refused |-> $stable(setpoint_select))
        else $error("refused write moved setpoint");
    a_margin_code: assert property (setpoint_select != 2'h3)
        else $error("unsupported margin selected");
    a_fault_decode: assert property (!(margin_faults_ignored && margin_faults_respond))
        else $error("both margin fault modes");
    a_ramp_in_on: assert property (ramp_down |-> output_enable)
        else $error("ramp while output off");

    c_refused: cover property (write_refused);
    c_ramp: cover property ($rose(ramp_down));
    c_off: cover property ($fell(output_enable));
endmodule : pmoc_control_assertions

bind pmoc_control pmoc_control_assertions #(.MS_CYCLES(MS_CYCLES)) u_chk (
    .clk(clk), .srst(srst), .cmd(cmd), .enable_pin(enable_pin),
    .off_delay_ms(off_delay_ms), .fall_time_ms(fall_time_ms), .rd_data(rd_data),
    .rd_valid(rd_valid), .write_refused(write_refused), .nominal_write_ok(nominal_write_ok),
    .nominal_write_data(nominal_write_data), .clear_status(clear_status),
    .alert_release(alert_release), .output_enable(output_enable), .ramp_down(ramp_down),
    .setpoint_select(setpoint_select), .margin_faults_ignored(margin_faults_ignored),
    .margin_faults_respond(margin_faults_respond)
);
`default_nettype wire

// *** pmoc_host.sv ***
// Host and enable pin driver model for the on/off command block.
// Assumes the bench calls its tasks; every change lands on a falling edge.
`timescale 1ns/1ps
`default_nettype none

module pmoc_host (
    input wire logic clk,
    output var pmoc_pkg::pmoc_cmd_t cmd,
    output var logic enable_pin
);
    import pmoc_pkg::*;

    // Holds one command over a single rising edge, then scrambles the idle bus.
    task automatic send(input logic w, input logic [7:0] code, input logic [7:0] data);
        @(negedge clk);
        cmd <= '{1'b1, w, code, data};
        @(negedge clk);
        cmd <= '{1'b0, ~w, ~code, ~data};
    endtask : send

    // Moves the raw enable pin.
    task automatic pin(input logic v);
        @(negedge clk);
        enable_pin <= v;
    endtask : pin

    // Idle bus and inactive pin at time zero.
    initial begin
        cmd = '0;
        enable_pin = 1'b0;
    end
endmodule : pmoc_host
`default_nettype wire

// *** pmoc_pkg.sv ***
// Package for the on/off and write-lock command block of a PMBus regulator.
// Assumes a PMBus front end on the same clock that decodes frames into commands.
package pmoc_pkg;

    // Command codes of the registers held here, of clear faults and of the nominal voltage command.
    localparam logic [7:0] PMOC_CODE_OPERATING = 8'h01;
    localparam logic [7:0] PMOC_CODE_SWITCH_CFG = 8'h02;
    localparam logic [7:0] PMOC_CODE_CLEAR_FAULTS = 8'h03;
    localparam logic [7:0] PMOC_CODE_WRITE_LOCK = 8'h10;
    localparam logic [7:0] PMOC_CODE_NOMINAL_VOUT = 8'h21;

    // Reset values.
    localparam logic [7:0] PMOC_OPERATING_RESET = 8'h88;
    localparam logic [7:0] PMOC_SWITCH_CFG_RESET = 8'h1f;
    localparam logic [7:0] PMOC_WRITE_LOCK_RESET = 8'h00;

    // Writable bit masks; the other bits read as zero.
    localparam logic [7:0] PMOC_OPERATING_MASK = 8'hfc;
    localparam logic [7:0] PMOC_SWITCH_CFG_MASK = 8'h1f;
    localparam logic [7:0] PMOC_WRITE_LOCK_MASK = 8'he0;

    // Field positions of the operating-state command.
    localparam int PMOC_OP_ON_BIT = 7;
    localparam int PMOC_OP_SEQ_OFF_BIT = 6;
    localparam int PMOC_OP_MARGIN_HI = 5;
    localparam int PMOC_OP_MARGIN_LO = 4;
    localparam int PMOC_OP_MFLT_HI = 3;
    localparam int PMOC_OP_MFLT_LO = 2;

    // Field positions of the on/off configuration.
    localparam int PMOC_CFG_POWER_UP_POLICY = 4;
    localparam int PMOC_CFG_CMD_USE = 3;
    localparam int PMOC_CFG_PIN_USE = 2;
    localparam int PMOC_CFG_ENABLE_PIN_POLARITY = 1;
    localparam int PMOC_CFG_PIN_OFF_MODE = 0;

    // Field position of the write-lock level.
    localparam int PMOC_LOCK_HI = 7;
    localparam int PMOC_LOCK_LO = 5;

    // Write-lock levels.
    localparam logic [2:0] PMOC_LOCK_NONE = 3'h0;
    localparam logic [2:0] PMOC_LOCK_ALL = 3'h4;
    localparam logic [2:0] PMOC_LOCK_OPERATING = 3'h2;
    localparam logic [2:0] PMOC_LOCK_CONFIG = 3'h1;

    // Margin and margin fault codes.
    localparam logic [1:0] PMOC_MARGIN_NOMINAL = 2'h0;
    localparam logic [1:0] PMOC_MARGIN_LOW = 2'h1;
    localparam logic [1:0] PMOC_MARGIN_HIGH = 2'h2;
    localparam logic [1:0] PMOC_MFLT_IGNORE = 2'h1;
    localparam logic [1:0] PMOC_MFLT_RESPOND = 2'h2;

    // Timing: the shutdown counts run in whole milliseconds.
    localparam int PMOC_CLK_PERIOD_PS = 25000;
    localparam int PMOC_MS_PS = 1000000000;
    localparam int PMOC_MS_CYCLES = PMOC_MS_PS / PMOC_CLK_PERIOD_PS;
    localparam int PMOC_MS_WIDTH = 7;

    // One decoded command from the PMBus front end.
    typedef struct packed {
        logic valid;
        logic write;
        logic [7:0] code;
        logic [7:0] data;
    } pmoc_cmd_t;

    // Output state of the power stage control.
    typedef enum logic [1:0] {
        PMOC_OFF,
        PMOC_ON,
        PMOC_OFF_DELAY,
        PMOC_FALL
    } pmoc_state_t;

endpackage : pmoc_pkg

// *** tb_pmbus_onoff_writelock_control.sv ***
// Self-checking bench for the on/off and write-lock command block.
// Assumes pmoc_host drives commands and the pin; shutdown counts are shortened.
`timescale 1ns/1ps
`default_nettype none

module tb_pmbus_onoff_writelock_control;
    import pmoc_pkg::*;
    localparam int MS = 4;
    logic clk = 1'b0;
    logic srst = 1'b1;
    pmoc_cmd_t cmd;
    logic enable_pin, rd_valid, write_refused, nominal_write_ok, clear_status;
    logic alert_release, output_enable, ramp_down, mf_ign, mf_rsp, ramp;
    logic [6:0] off_delay_ms = 7'h01;
    logic [6:0] fall_time_ms = 7'h01;
    logic [7:0] rd_data, nominal_write_data;
    logic [1:0] setpoint_select;
    int mismatches = 0;
    int num_checks = 0;
    int cycles = 0;
    int n;

    pmoc_host host (.clk(clk), .cmd(cmd), .enable_pin(enable_pin));
    pmoc_control #(.MS_CYCLES(MS)) uut (
        .clk(clk), .srst(srst), .cmd(cmd), .enable_pin(enable_pin),
        .off_delay_ms(off_delay_ms), .fall_time_ms(fall_time_ms), .rd_data(rd_data),
        .rd_valid(rd_valid), .write_refused(write_refused),
        .nominal_write_ok(nominal_write_ok), .nominal_write_data(nominal_write_data),
        .clear_status(clear_status), .alert_release(alert_release),
        .output_enable(output_enable), .ramp_down(ramp_down),
        .setpoint_select(setpoint_select), .margin_faults_ignored(mf_ign),
        .margin_faults_respond(mf_rsp)
    );

    // Clock at 40 MHz and a hang limit.
    always #12.5 clk = ~clk;
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            mismatches++;
            conclude();
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        num_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic rd(input logic [7:0] code, input logic [7:0] exp);
        host.send(1'b0, code, 8'h00);
        chk("read valid", 8'h01, {7'h00, rd_valid});
        chk("read data", exp, rd_data);
    endtask : rd
    task automatic wr(input logic [7:0] code, input logic [7:0] data, input logic ok);
        host.send(1'b1, code, data);
        chk("refused", {7'h00, !ok}, {7'h00, write_refused});
    endtask : wr
    // Waits for a level on the output enable, noting cycles spent and any ramp.
    task automatic wait_oe(input logic lvl);
        n = 0;
        ramp = 1'b0;
        while (output_enable !== lvl && n < 200) begin
            @(negedge clk);
            n++;
            ramp = ramp | (ramp_down === 1'b1);
        end
    endtask : wait_oe

    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_reset();
        rd(PMOC_CODE_OPERATING, PMOC_OPERATING_RESET);
        rd(PMOC_CODE_SWITCH_CFG, PMOC_SWITCH_CFG_RESET);
        rd(PMOC_CODE_WRITE_LOCK, PMOC_WRITE_LOCK_RESET);
        rd(8'h55, 8'h00);
        chk("off at reset", 8'h00, {7'h00, output_enable});
        host.pin(1'b1);
        wait_oe(1'b1);
        chk("turn on cycles", 8'h03, n[7:0]);
    endtask : t_reset

    task automatic t_lock();
        logic [2:0] lv [4] = '{3'h0, 3'h4, 3'h2, 3'h1};
        logic [3:0] ok [4] = '{4'hf, 4'h0, 4'h1, 4'h7};
        for (int i = 0; i < 4; i++) begin
            wr(PMOC_CODE_WRITE_LOCK, {lv[i], 5'h1f}, 1'b1);
            rd(PMOC_CODE_WRITE_LOCK, {lv[i], 5'h00});
            wr(PMOC_CODE_OPERATING, 8'h98, ok[i][0]);
            @(negedge clk);
            chk("setpoint", {7'h00, ok[i][0]}, {6'h00, setpoint_select});
            if (ok[i][0]) wr(PMOC_CODE_OPERATING, 8'h88, 1'b1);
            wr(PMOC_CODE_SWITCH_CFG, 8'h1f, ok[i][1]);
            wr(PMOC_CODE_NOMINAL_VOUT, 8'h5a, ok[i][2]);
            chk("nominal ok", {7'h00, ok[i][2]}, {7'h00, nominal_write_ok});
            chk("nominal data", 8'h5a, nominal_write_data);
            wr(PMOC_CODE_CLEAR_FAULTS, 8'h00, ok[i][3]);
            chk("clear", {6'h00, {2{ok[i][3]}}}, {6'h00, clear_status, alert_release});
        end
        wr(PMOC_CODE_WRITE_LOCK, 8'h00, 1'b1);
    endtask : t_lock

    task automatic t_margin();
        for (int m = 0; m < 4; m++) begin
            for (int f = 1; f < 3; f++) begin
                wr(PMOC_CODE_OPERATING, {2'b10, m[1:0], f[1:0], 2'b00}, m != 3);
                @(negedge clk);
                chk("margin", (m == 3) ? 8'h02 : m[7:0], {6'h00, setpoint_select});
                chk("faults", (m == 3) ? 8'h02 : {6'h00, f[1:0]}, {6'h00, mf_rsp, mf_ign});
            end
        end
        wr(PMOC_CODE_OPERATING, 8'h80, 1'b0);
        wr(PMOC_CODE_OPERATING, 8'h88, 1'b1);
    endtask : t_margin

    task automatic t_seq();
        wr(PMOC_CODE_OPERATING, 8'h48, 1'b1);
        wait_oe(1'b0);
        chk("ramp seen", 8'h01, {7'h00, ramp});
        chk("delay and fall", 8'h01, {7'h00, n >= 2 * MS && n <= 2 * MS + 3});
        wr(PMOC_CODE_OPERATING, 8'h88, 1'b1);
        wait_oe(1'b1);
        chk("cmd on", 8'h01, {7'h00, n <= 3});
        wr(PMOC_CODE_OPERATING, 8'h08, 1'b1);
        wait_oe(1'b0);
        chk("fast off", 8'h01, {7'h00, n <= 3 && !ramp});
        wr(PMOC_CODE_OPERATING, 8'h88, 1'b1);
        wait_oe(1'b1);
    endtask : t_seq

    task automatic t_pin();
        host.pin(1'b0);
        wait_oe(1'b0);
        chk("pin fast off", 8'h01, {7'h00, n <= 5 && !ramp});
        wr(PMOC_CODE_SWITCH_CFG, 8'h1d, 1'b1);
        wait_oe(1'b1);
        chk("active low on", 8'h01, {7'h00, n <= 6});
        wr(PMOC_CODE_SWITCH_CFG, 8'h1c, 1'b1);
        host.pin(1'b1);
        wait_oe(1'b0);
        chk("pin seq off", 8'h01, {7'h00, ramp && n >= 2 * MS});
    endtask : t_pin

    // Pin ignored, on bit ignored, then power-up policy zero with the pin inactive.
    task automatic t_cfg();
        wr(PMOC_CODE_SWITCH_CFG, 8'h18, 1'b1);
        wait_oe(1'b1);
        chk("pin unused on", 8'h01, {7'h00, output_enable});
        wr(PMOC_CODE_SWITCH_CFG, 8'h10, 1'b1);
        wr(PMOC_CODE_OPERATING, 8'h08, 1'b1);
        repeat (4) @(negedge clk);
        chk("on bit ignored", 8'h01, {7'h00, output_enable});
        wr(PMOC_CODE_SWITCH_CFG, 8'h0c, 1'b1);
        wait_oe(1'b0);
        chk("policy cmd off", 8'h00, {7'h00, output_enable});
        wr(PMOC_CODE_OPERATING, 8'h88, 1'b1);
        wait_oe(1'b1);
        chk("policy on", 8'h01, {7'h00, output_enable && n <= 3});
    endtask : t_cfg

    task automatic conclude();
        $display("Checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : conclude

    // Reset for 20 cycles, then the scenarios in turn.
    initial begin
        repeat (20) @(negedge clk);
        srst = 1'b0;
        t_reset();
        t_lock();
        t_margin();
        t_seq();
        t_pin();
        t_cfg();
        conclude();
    end
endmodule : tb_pmbus_onoff_writelock_control
`default_nettype wire
